//--- design/sop_array.sv
// Sum-of-products macrocell array with AXI4-Lite configuration port.
// Assumes pins reach it asynchronously and software loads the pattern while stopped.
`include "sop_consts.svh"
`default_nettype none

module sop_array
  import sop_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // AXI4-Lite write address and data
  input wire logic [`SOP_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [`SOP_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Dedicated inputs
  input wire logic [`SOP_N_IN-1:0] IN_PIN,
  // Macrocell pins
  input wire logic [`SOP_N_MC-1:0] IO_IN,
  output logic [`SOP_N_MC-1:0] IO_OUT,
  output logic [`SOP_N_MC-1:0] IO_OE_N
);

  ////////////////////////////////////////////////////////////////////////////////
  // Term allotment: grows toward the middle cells

  function automatic int pt_count(input int mc);
    int d;
    d = (mc < `SOP_N_MC - 1 - mc) ? mc : `SOP_N_MC - 1 - mc;
    return `SOP_PT_MIN + `SOP_PT_STEP * d;
  endfunction

  function automatic int pt_base(input int mc);
    int b;
    b = 0;
    for (int k = 0; k < mc; k++) begin
      b = b + pt_count(k);
    end
    return b;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

  localparam logic [9:0] ARR_IDX = 10'(`SOP_ADDR_ARRAY >> 2);

  sop_state_t s;
  sop_state_t n;

  logic [`SOP_N_IN-1:0] in_sync;
  logic [`SOP_N_MC-1:0] io_sync;
  logic [`SOP_N_ARR_IN-1:0] arr_in;
  logic [`SOP_TERM_W-1:0] lits;
  logic [`SOP_N_TERMS-1:0] term;
  logic [`SOP_N_MC-1:0] sum;
  logic [`SOP_N_MC-1:0] q_eff;
  logic [`SOP_N_MC-1:0] fb;
  logic [`SOP_N_MC-1:0] path_val;
  logic [`SOP_N_MC-1:0] mc_out;
  logic [`SOP_N_MC-1:0] oe;
  logic clear_on;
  logic preset_on;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  sop_sync #(.W(`SOP_N_IN)) u_in_sync (
    .clk(REF_CLK),
    .rst(RST),
    .pin(IN_PIN),
    .level(in_sync)
  );

  // Pin levels come back even while driven, so combinatorial feedback sees the pin
  sop_sync #(.W(`SOP_N_MC)) u_io_sync (
    .clk(REF_CLK),
    .rst(RST),
    .pin(IO_IN),
    .level(io_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // AND plane

  assign arr_in = {fb, in_sync};

  genvar gi;
  generate
    for (gi = 0; gi < `SOP_N_ARR_IN; gi++) begin : g_lit
      assign lits[2*gi] = arr_in[gi];
      assign lits[2*gi+1] = ~arr_in[gi];
    end
    for (gi = 0; gi < `SOP_N_TERMS; gi++) begin : g_term
      sop_pterm u_pterm (
        .conn(s.arr[gi]),
        .lits(lits),
        .term(term[gi])
      );
    end
  endgenerate

  // Control terms only act while running
  assign clear_on = s.run & term[`SOP_AR_TERM];
  assign preset_on = s.run & term[`SOP_SP_TERM];

  ////////////////////////////////////////////////////////////////////////////////
  // Fixed OR plane and macrocells

  genvar gm;
  genvar gj;
  generate
    for (gm = 0; gm < `SOP_N_MC; gm++) begin : g_mc
      localparam int CNT = pt_count(gm);
      localparam int BASE = pt_base(gm);
      logic [`SOP_PT_MAX-1:0] hits;
      for (gj = 0; gj < `SOP_PT_MAX; gj++) begin : g_hit
        if (gj < CNT) begin : g_on
          assign hits[gj] = term[BASE+gj];
        end else begin : g_off
          assign hits[gj] = 1'b0;
        end
      end
      assign sum[gm] = |hits;
    end
  endgenerate

  // Clear takes the flop low at once, not waiting for an edge
  assign q_eff = s.q & ~{`SOP_N_MC{clear_on}};

  always_comb begin
    for (int k = 0; k < `SOP_N_MC; k++) begin
      fb[k] = s.path[k] ? io_sync[k] : ~q_eff[k];
      path_val[k] = s.path[k] ? sum[k] : q_eff[k];
      mc_out[k] = s.pol[k] ? path_val[k] : ~path_val[k];
      oe[k] = s.run & term[`SOP_OE_BASE + k];
    end
  end

  // Combinatorial path is the device's own timing, so the pins are not re-registered
  assign IO_OUT = mc_out;
  assign IO_OE_N = ~oe;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read mux

  always_comb begin
    logic [9:0] widx;
    logic [9:0] aidx;
    widx = S_AXI_ARADDR[11:2];
    aidx = widx - ARR_IDX;
    rd_data = 32'h0;
    rd_resp = `SOP_RESP_OKAY;
    if (S_AXI_ARADDR[1:0] != 2'h0) begin
      rd_resp = `SOP_RESP_SLVERR;
    end else if (widx >= ARR_IDX && aidx < `SOP_ARR_WORDS) begin
      if (aidx[0]) begin
        rd_data[`SOP_ARR_HI_W-1:0] = s.arr[aidx[9:1]][`SOP_TERM_W-1:32];
      end else begin
        rd_data = s.arr[aidx[9:1]][31:0];
      end
    end else begin
      case (S_AXI_ARADDR)
        `SOP_ADDR_CTRL: begin
          rd_data[`SOP_CTRL_RUN_BIT] = s.run;
        end
        `SOP_ADDR_MCFG: begin
          rd_data[`SOP_MCFG_POL_LSB +: `SOP_N_MC] = s.pol;
          rd_data[`SOP_MCFG_PATH_LSB +: `SOP_N_MC] = s.path;
        end
        `SOP_ADDR_PRELOAD: begin
          rd_data[`SOP_N_MC-1:0] = q_eff;
        end
        `SOP_ADDR_PINS: begin
          rd_data[`SOP_N_IN-1:0] = in_sync;
          rd_data[`SOP_PINS_IO_LSB +: `SOP_N_MC] = io_sync;
        end
        `SOP_ADDR_OUTS: begin
          rd_data[`SOP_N_MC-1:0] = mc_out;
          rd_data[`SOP_OUTS_OE_LSB +: `SOP_N_MC] = oe;
        end
        default: begin
          rd_resp = `SOP_RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [9:0] widx;
    logic [9:0] aidx;
    logic [31:0] mw;
    logic [`SOP_TERM_W-1:0] word;
    widx = s.aw_addr[11:2];
    aidx = widx - ARR_IDX;
    mw = 32'h0;
    word = s.arr[aidx[9:1]];
    n = s;

    // Macrocell flops; clear beats preset, preset beats the sum
    if (s.run) begin
      if (clear_on) begin
        n.q = '0;
      end else if (preset_on) begin
        n.q = '1;
      end else begin
        n.q = sum;
      end
    end

    // Write channel: address and data may come in either order
    // No new write is taken while its answer is pending
    if (S_AXI_AWVALID && !s.aw_got && !s.bvalid) begin
      n.aw_got = 1'b1;
      n.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s.w_got && !s.bvalid) begin
      n.w_got = 1'b1;
      n.w_data = S_AXI_WDATA;
      n.w_strb = S_AXI_WSTRB;
    end
    if (s.bvalid && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `SOP_RESP_OKAY;
      if (s.aw_addr[1:0] != 2'h0) begin
        n.bresp = `SOP_RESP_SLVERR;
      end else if (widx >= ARR_IDX && aidx < `SOP_ARR_WORDS) begin
        // Pattern changes only while stopped, so no term glitches mid-run
        if (s.run) begin
          n.bresp = `SOP_RESP_SLVERR;
        end else if (aidx[0]) begin
          mw = merge(32'(word[`SOP_TERM_W-1:32]), s.w_data, s.w_strb);
          word[`SOP_TERM_W-1:32] = mw[`SOP_ARR_HI_W-1:0];
          n.arr[aidx[9:1]] = word;
        end else begin
          word[31:0] = merge(word[31:0], s.w_data, s.w_strb);
          n.arr[aidx[9:1]] = word;
        end
      end else begin
        case (s.aw_addr)
          `SOP_ADDR_CTRL: begin
            if (s.w_strb[0]) begin
              n.run = s.w_data[`SOP_CTRL_RUN_BIT];
            end
          end
          `SOP_ADDR_MCFG: begin
            if (s.run) begin
              n.bresp = `SOP_RESP_SLVERR;
            end else begin
              mw = merge({6'h0, s.path, 6'h0, s.pol}, s.w_data, s.w_strb);
              n.pol = mw[`SOP_MCFG_POL_LSB +: `SOP_N_MC];
              n.path = mw[`SOP_MCFG_PATH_LSB +: `SOP_N_MC];
            end
          end
          `SOP_ADDR_PRELOAD: begin
            // Preload while running would race the array's own load
            if (s.run) begin
              n.bresp = `SOP_RESP_SLVERR;
            end else begin
              mw = merge(32'(s.q), s.w_data, s.w_strb);
              n.q = mw[`SOP_N_MC-1:0];
            end
          end
          default: begin
            n.bresp = `SOP_RESP_SLVERR;
          end
        endcase
      end
    end

    // Read channel
    if (s.rvalid && S_AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rdata = rd_data;
      n.rresp = rd_resp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; polarity and path bits come up high, the array pattern and the rest come up low

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
      s.pol <= `SOP_MCFG_RST;
      s.path <= `SOP_MCFG_RST;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus outputs

  assign S_AXI_AWREADY = ~s.aw_got & ~s.bvalid;
  assign S_AXI_WREADY = ~s.w_got & ~s.bvalid;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_ARREADY = ~s.rvalid;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RDATA = s.rdata;
  assign S_AXI_RRESP = s.rresp;

endmodule

`default_nettype wire

//--- design/sop_consts.svh
// Constants of the sum-of-products macrocell array: sizes, offsets, fields, resets.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SOP_CONSTS_SVH
`define SOP_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Array geometry
`define SOP_N_IN 12
`define SOP_N_MC 10
`define SOP_N_ARR_IN 22
`define SOP_TERM_W 44
`define SOP_N_TERMS 132
`define SOP_OE_BASE 120
`define SOP_AR_TERM 130
`define SOP_SP_TERM 131
`define SOP_PT_MIN 8
`define SOP_PT_STEP 2
`define SOP_PT_MAX 16

////////////////////////////////////////////////////////////////////////////////
// Register map (byte addresses)
`define SOP_ADDR_W 12
`define SOP_ADDR_CTRL 12'h000
`define SOP_ADDR_MCFG 12'h004
`define SOP_ADDR_PRELOAD 12'h008
`define SOP_ADDR_PINS 12'h00c
`define SOP_ADDR_OUTS 12'h010
`define SOP_ADDR_ARRAY 12'h400
`define SOP_ARR_WORDS 10'h108

////////////////////////////////////////////////////////////////////////////////
// Fields and reset values
`define SOP_CTRL_RUN_BIT 0
`define SOP_MCFG_POL_LSB 0
`define SOP_MCFG_PATH_LSB 16
`define SOP_PINS_IO_LSB 16
`define SOP_OUTS_OE_LSB 16
`define SOP_ARR_HI_W 12
`define SOP_MCFG_RST 10'h3ff
`define SOP_RESP_OKAY 2'h0
`define SOP_RESP_SLVERR 2'h2

`endif

//--- design/sop_pkg.sv
// Types of the sum-of-products macrocell array.
// Assumes sop_consts.svh on the include path.
`include "sop_consts.svh"
`default_nettype none

package sop_pkg;

  typedef logic [`SOP_TERM_W-1:0] sop_term_t;

  // Whole state of the top module
  typedef struct packed {
    logic run;
    logic [`SOP_N_MC-1:0] pol;
    logic [`SOP_N_MC-1:0] path;
    logic [`SOP_N_MC-1:0] q;
    logic [`SOP_N_TERMS-1:0][`SOP_TERM_W-1:0] arr;
    logic aw_got;
    logic [`SOP_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sop_state_t;

endpackage

`default_nettype wire

//--- design/sop_pterm.sv
// One product term of the programmable AND plane.
// Assumes a literal vector holding each input true then inverted.
`include "sop_consts.svh"
`default_nettype none

module sop_pterm (
  // Connection pattern and literals
  input wire logic [`SOP_TERM_W-1:0] conn,
  input wire logic [`SOP_TERM_W-1:0] lits,
  // Result
  output logic term
);

  // Open connections count as one; true and inverted of one input give zero
  assign term = &(~conn | lits);

endmodule

`default_nettype wire

//--- design/sop_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels and one design clock.
`include "sop_consts.svh"
`default_nettype none

module sop_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin side
  input wire logic [W-1:0] pin,
  // Design side
  output logic [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } sop_sync_t;

  sop_sync_t s;
  sop_sync_t n;

  ////////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second; a change counts once stages two and three agree
  always_comb begin
    n = s;
    n.s1 = pin;
    n.s2 = s.s1;
    n.s3 = s.s2;
    for (int i = 0; i < W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        n.stable[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign level = s.stable;

endmodule

`default_nettype wire

//--- test/sop_array_assertions.sv
// Bus and driver checks for the macrocell array top.
// Assumes one clock domain; bound onto every sop_array.
`include "sop_consts.svh"
`default_nettype none

module sop_array_assertions
  import sop_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register bus
  input wire logic [`SOP_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [`SOP_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Pins
  input wire logic [`SOP_N_IN-1:0] IN_PIN,
  input wire logic [`SOP_N_MC-1:0] IO_IN,
  input wire logic [`SOP_N_MC-1:0] IO_OUT,
  input wire logic [`SOP_N_MC-1:0] IO_OE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  // Set once any write answered; drivers stay off before that
  logic wrote;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wrote <= 1'h0;
    end else if (S_AXI_BVALID) begin
      wrote <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_write_answer: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write not answered");
  chk_bresp_stands: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  chk_bresp_ends: assert property (
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  chk_write_blocked: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answer pending");
  chk_bresp_code: assert property (
    S_AXI_BVALID |-> S_AXI_BRESP inside {`SOP_RESP_OKAY, `SOP_RESP_SLVERR})
    else $error("illegal write response");
  chk_read_answer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
  chk_rdata_stands: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data changed");
  chk_read_blocked: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  chk_drivers_idle: assert property (
    !wrote && !S_AXI_BVALID |-> &IO_OE_N)
    else $error("pin driven before start");

  cover property (S_AXI_BVALID && S_AXI_BRESP == `SOP_RESP_SLVERR);
  cover property (S_AXI_RVALID && S_AXI_RREADY);
  cover property (!IO_OE_N[1]);
  cover property (S_AXI_RVALID && !S_AXI_RREADY);
endmodule

bind sop_array sop_array_assertions chk (.*);

`default_nettype wire

//--- test/sop_array_test.sv
// Self-checking bench for the macrocell array.
// Assumes the checker is bound in and the board model resolves pins.
`include "sop_consts.svh"
`default_nettype none

module sop_array_test
  import sop_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic awv = 1'h0;
  logic wv = 1'h0;
  logic bready = 1'h0;
  logic arv = 1'h0;
  logic rready = 1'h0;
  logic [11:0] in_pin = 12'h000;
  logic [3:0] wstrb = 4'hf;
  // Cycles before bready or rready rise, so the slave must stall
  int lag = 0;
  logic [9:0] drv = 10'h000;
  logic [9:0] io_in, io_out, io_oe_n;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int n_fail = 0;
  int checks_done = 0;

  sop_array uut (.REF_CLK(ref_clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IN_PIN(in_pin), .IO_IN(io_in),
    .IO_OUT(io_out), .IO_OE_N(io_oe_n));
  sop_board board (.dev_out(io_out), .dev_oe_n(io_oe_n), .drv(drv), .drv_en(10'h3ff),
    .pin(io_in));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ckb(input string nm, input int k, input logic e);
    chk(nm, {31'h0, io_out[k]}, {31'h0, e});
  endtask

  // Handshakes are judged at the falling edge, acted on at the next rise
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'(lag == 0);
    do begin
      @(negedge ref_clk);
      ta = awready;
      tw = wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge ref_clk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
      n++;
      if (n >= lag && !tb) bready <= 1'h1;
    end while (!tb && n < 40);
    bready <= 1'h0;
    chk("bvalid", {31'h0, tb}, 32'h1);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ta, tr;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge ref_clk);
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'(lag == 0);
    do begin
      @(negedge ref_clk);
      ta = arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge ref_clk);
      if (ta) arv <= 1'h0;
      n++;
      if (n >= lag && !tr) rready <= 1'h1;
    end while (!tr && n < 40);
    rready <= 1'h0;
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask

  // Pins pass three flops and a filter, so wait well past that
  task automatic set(input logic [11:0] p, input logic [9:0] b);
    @(posedge ref_clk);
    in_pin <= p;
    drv <= b;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    rd(`SOP_ADDR_CTRL, `SOP_RESP_OKAY, d);
    chk("ctrl", d, 32'h0);
    rd(`SOP_ADDR_MCFG, `SOP_RESP_OKAY, d);
    chk("mcfg", d, 32'h03ff03ff);
    rd(`SOP_ADDR_PRELOAD, `SOP_RESP_OKAY, d);
    chk("q_reset", d, 32'h0);
    wstrb <= 4'h4;
    wr(`SOP_ADDR_MCFG, 32'h0, `SOP_RESP_OKAY);
    wstrb <= 4'hf;
    rd(`SOP_ADDR_MCFG, `SOP_RESP_OKAY, d);
    chk("mcfg_strb", d, 32'h030003ff);
    wr(`SOP_ADDR_MCFG, 32'h03ff03ff, `SOP_RESP_OKAY);
    wr(12'h81c, 32'hffffffff, `SOP_RESP_OKAY);
    rd(12'h81c, `SOP_RESP_OKAY, d);
    chk("arr_hi", d, 32'h00000fff);
    wr(12'h81c, 32'h0, `SOP_RESP_OKAY);
    rd(12'h020, `SOP_RESP_SLVERR, d);
    rd(12'h00a, `SOP_RESP_SLVERR, d);
    set(12'h000, 10'h000);
    chk("oe_n", {22'h0, io_oe_n}, 32'h3ff);
    chk("out", {22'h0, io_out}, 32'h3ff);
    $display("test reset done");
    for (int t = 0; t < 8; t++) begin
      wr(12'h400 + 12'(8 * t), 32'h3, `SOP_RESP_OKAY);
    end
    set(12'h000, 10'h000);
    ckb("both_pol", 0, 1'h0);
    wr(12'h400, 32'h1, `SOP_RESP_OKAY);
    set(12'h001, 10'h000);
    ckb("true_hi", 0, 1'h1);
    set(12'h000, 10'h000);
    ckb("true_lo", 0, 1'h0);
    wr(12'h400, 32'h2, `SOP_RESP_OKAY);
    set(12'h000, 10'h000);
    ckb("inverted", 0, 1'h1);
    wr(`SOP_ADDR_MCFG, 32'h03ff03fe, `SOP_RESP_OKAY);
    set(12'h000, 10'h000);
    ckb("pol_low", 0, 1'h0);
    $display("test and plane done");
    for (int t = 18; t < 30; t++) begin
      wr(12'h400 + 12'(8 * t), (t == 18) ? 32'h01000000 : 32'h3, `SOP_RESP_OKAY);
    end
    set(12'h000, 10'h000);
    ckb("fb_pin", 2, 1'h0);
    set(12'h000, 10'h001);
    ckb("fb_pin", 2, 1'h1);
    set(12'h0a4, 10'h001);
    rd(`SOP_ADDR_PINS, `SOP_RESP_OKAY, d);
    chk("pins", d, 32'h000100a4);
    $display("test feedback done");
    for (int t = 8; t < 18; t++) begin
      wr(12'h400 + 12'(8 * t), (t == 8) ? 32'h4 : 32'h3, `SOP_RESP_OKAY);
    end
    wr(12'h810, 32'h10, `SOP_RESP_OKAY);
    wr(12'h818, 32'h40, `SOP_RESP_OKAY);
    wr(`SOP_ADDR_MCFG, 32'h03fd03fe, `SOP_RESP_OKAY);
    lag = 3;
    wr(`SOP_ADDR_PRELOAD, 32'h2aa, `SOP_RESP_OKAY);
    rd(`SOP_ADDR_PRELOAD, `SOP_RESP_OKAY, d);
    lag = 0;
    chk("preload", d, 32'h2aa);
    set(12'h002, 10'h001);
    ckb("reg_q", 1, 1'h1);
    wr(`SOP_ADDR_PRELOAD, 32'h0, `SOP_RESP_OKAY);
    set(12'h002, 10'h001);
    ckb("reg_q", 1, 1'h0);
    wr(`SOP_ADDR_CTRL, 32'h1, `SOP_RESP_OKAY);
    set(12'h002, 10'h001);
    ckb("capture", 1, 1'h1);
    chk("oe_n1", {31'h0, io_oe_n[1]}, 32'h0);
    rd(`SOP_ADDR_OUTS, `SOP_RESP_OKAY, d);
    chk("outs", d, 32'h03ff03fa);
    wr(12'h400, 32'h0, `SOP_RESP_SLVERR);
    wr(`SOP_ADDR_MCFG, 32'h0, `SOP_RESP_SLVERR);
    set(12'h000, 10'h001);
    ckb("capture", 1, 1'h0);
    set(12'h008, 10'h001);
    ckb("preset", 1, 1'h1);
    set(12'h00c, 10'h001);
    ckb("clear", 1, 1'h0);
    wr(`SOP_ADDR_CTRL, 32'h0, `SOP_RESP_OKAY);
    wr(`SOP_ADDR_MCFG, 32'h03fd03fc, `SOP_RESP_OKAY);
    set(12'h00c, 10'h001);
    ckb("reg_low", 1, 1'h1);
    $display("test register done");
    conclude;
  end

  // Whole run is some 340 cycles
  initial begin
    #50000;
    n_fail++;
    conclude;
  end
endmodule

`default_nettype wire

//--- test/sop_board.sv
// Board around the macrocell pins: a driver per pin plus pull-ups.
// Assumes the device enable is active low and wins over the board.
`include "sop_consts.svh"
`default_nettype none

module sop_board (
  // Device side
  input wire logic [`SOP_N_MC-1:0] dev_out,
  input wire logic [`SOP_N_MC-1:0] dev_oe_n,
  // Board side
  input wire logic [`SOP_N_MC-1:0] drv,
  input wire logic [`SOP_N_MC-1:0] drv_en,
  // Resolved level
  output logic [`SOP_N_MC-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pin floats to the pull-up, never to a stale value
  assign pin = (~dev_oe_n & dev_out) | (dev_oe_n & drv_en & drv) | (dev_oe_n & ~drv_en);
endmodule

`default_nettype wire
